/* ess_top.sv */
// Emergency stop sequencer with APB register access.
// What this block does
// (R1) Stop on external request, controller power loss, or servo alarm.
// (R2) Deceleration mode keeps ready on, ramps down, then brakes dynamically.
// (R3) Time constant is time from rapid speed to zero, 0..5000 ms.
// (R4) Ramp slope is fixed, independent of the speed at stop start.
// (R5) Time constant zero gives an immediate position-loop step stop.
// (R6) Hand over to dynamic brake at 60 r/min or below.
// (R7) Power failure during deceleration abandons the ramp for the brake.
// (R8) Holding-brake output switches together with the dynamic brake.
// (R9) Alarm with dynamic-brake method skips deceleration, whatever the mode.
// (R10) Servo_word_a word bit 0: 0 deceleration stop, 1 dynamic brake stop.
// (R11) Dynamic brake mode brakes both at once when the stop occurs.
// (R12) Software should set time constant equal to rapid acceleration constant.
// (R13) Decrement per cycle is rapid speed over cycles; clamp at zero.
`timescale 1ns/1ps
module ess_top
	import ess_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Stop causes from pins
	input  wire logic        ext_stop_in,
	input  wire logic        power_loss_in,
	input  wire logic        servo_alarm_in,
	input  wire logic        alarm_db_in,
	// Motor side
	input  wire logic [15:0] speed_req,
	input  wire logic [15:0] motor_speed_fb,
	output logic [15:0]      speed_cmd,
	output logic             ready,
	output logic             dyn_brake,
	output logic             hold_brake,
	output logic             step_stop
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Ramp step in 16.16 fixed point; a zero t_ms gives a zero step.
	function automatic logic [31:0] ramp_step(input logic [15:0] rapid,
		input logic [15:0] t_ms);
		logic [47:0] num;
		logic [47:0] den;
		num = {16'h0000, rapid, 16'h0000};
		den = 48'(t_ms) * 48'(CYC_PER_MS);
		if (den == 48'h0) begin
			ramp_step = 32'h0000_0000;
		end else begin
			ramp_step = 32'(num / den);
		end
	endfunction : ramp_step

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0]        servo_servo_word_a_word_q;
	logic [15:0]        decel_time_param_q;
	logic [15:0]        rapid_speed_q;
	logic               brake_ctl_q;
	logic               restart_q;
	ess_state_t         state_q;
	ess_state_t         state_d;
	logic [31:0]        cmd_q;
	logic [31:0]        cmd_d;
	logic [31:0]        step_q;
	logic [SYNC_W-1:0]  s1_q;
	logic [SYNC_W-1:0]  s2_q;
	logic [SYNC_W-1:0]  s3_q;
	logic [SYNC_W-1:0]  cause_q;
	logic               ext_stop;
	logic               pwr_loss;
	logic               alarm;
	logic               alarm_db;
	logic               stop_any;
	logic               db_direct;
	logic               at_handover;
	logic               apb_wr;
	logic               apb_hit;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// A change is accepted once the second and third stages agree.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			cause_q <= '0;
		end else if (ce) begin
			s1_q <= {alarm_db_in, servo_alarm_in, power_loss_in, ext_stop_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < SYNC_W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					cause_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign ext_stop = cause_q[0];
	assign pwr_loss = cause_q[1];
	assign alarm    = cause_q[2];
	assign alarm_db = cause_q[2] & cause_q[3];
	// (R1) three stop causes
	assign stop_any = ext_stop | pwr_loss | alarm;
	// (R10) stop method select
	// (R9) brake-method alarm (alarm_db) forces brake
	assign db_direct = servo_servo_word_a_word_q[SERVO_WORD_A_DB_BIT] | alarm_db | pwr_loss;
	// (R6) handover speed
	assign at_handover = (motor_speed_fb <= DB_SPEED_RPM) || (cmd_q == '0);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	assign apb_hit = (paddr == OFS_SERVO_WORD_A) || (paddr == OFS_DECEL) ||
		(paddr == OFS_RAPID) || (paddr == OFS_CTRL) ||
		(paddr == OFS_STATUS);
	assign pslverr = psel & penable & ~apb_hit;
	assign apb_wr  = psel & penable & pwrite & ce;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			servo_servo_word_a_word_q  <= SERVO_WORD_A_RST;
			decel_time_param_q <= DECEL_RST;
			rapid_speed_q      <= RAPID_RST;
			brake_ctl_q        <= CTRL_BRK_RST;
			restart_q          <= 1'b0;
		end else if (ce) begin
			restart_q <= 1'b0;
			if (apb_wr) begin
				case (paddr)
					OFS_SERVO_WORD_A: begin
						servo_servo_word_a_word_q <= pwdata[15:0];
					end
					// (R3) clamp to legal range
					OFS_DECEL: begin
						if (pwdata[15:0] > DECEL_MS_MAX) begin
							decel_time_param_q <= DECEL_MS_MAX;
						end else begin
							decel_time_param_q <= pwdata[15:0];
						end
					end
					OFS_RAPID: begin
						rapid_speed_q <= pwdata[15:0];
					end
					OFS_CTRL: begin
						brake_ctl_q <= pwdata[CTRL_BRK_BIT];
						restart_q   <= pwdata[CTRL_RESTART];
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			OFS_SERVO_WORD_A:   prdata = {16'h0000, servo_servo_word_a_word_q};
			OFS_DECEL:  prdata = {16'h0000, decel_time_param_q};
			OFS_RAPID:  prdata = {16'h0000, rapid_speed_q};
			OFS_CTRL:   prdata = {31'h0, brake_ctl_q};
			OFS_STATUS: prdata = {20'h0, cause_q, 2'h0, state_q,
				hold_brake, dyn_brake, ready, step_stop};
			default:    prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Stop sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cmd_d   = cmd_q;
		case (state_q)
			ST_RUN: begin
				cmd_d = {speed_req, 16'h0000};
				if (stop_any) begin
					// (R11) brake at once
					if (db_direct) begin
						state_d = ST_BRAKE;
						cmd_d   = '0;
					// (R5) zero time step stop
					end else if (decel_time_param_q == 16'h0000) begin
						state_d = ST_STEP;
						cmd_d   = '0;
					// (R4) start from present speed
					end else begin
						state_d = ST_DECEL;
						cmd_d   = {motor_speed_fb, 16'h0000};
					end
				end
			end
			ST_DECEL: begin
				// (R13) fixed decrement, clamp
				if (cmd_q > step_q) begin
					cmd_d = cmd_q - step_q;
				end else begin
					cmd_d = '0;
				end
				// (R7) power loss aborts ramp
				// (R2) brake at handover speed or ramp end
				if (pwr_loss || alarm_db || at_handover) begin
					state_d = ST_BRAKE;
					cmd_d   = '0;
				end
			end
			ST_STEP: begin
				cmd_d = '0;
				if (pwr_loss || alarm_db ||
					(motor_speed_fb <= DB_SPEED_RPM)) begin
					state_d = ST_BRAKE;
				end
			end
			ST_BRAKE: begin
				cmd_d = '0;
				if (restart_q && !stop_any) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_BRAKE;
				cmd_d   = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_RUN;
			cmd_q   <= '0;
			step_q  <= '0;
		end else if (ce) begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			// (R4) slope latched at entry
			if (state_q == ST_RUN) begin
				step_q <= ramp_step(rapid_speed_q, decel_time_param_q);
			end
		end
	end

	// Outputs follow the next state so all change on one edge.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			speed_cmd  <= 16'h0000;
			ready      <= 1'b1;
			dyn_brake  <= 1'b0;
			hold_brake <= 1'b0;
			step_stop  <= 1'b0;
		end else if (ce) begin
			speed_cmd  <= cmd_d[31:16];
			ready      <= (state_d != ST_BRAKE);
			dyn_brake  <= (state_d == ST_BRAKE);
			// (R8) hold brake with dynamic brake
			hold_brake <= (state_d == ST_BRAKE) & brake_ctl_q;
			step_stop  <= (state_d == ST_STEP);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence seq_run_stop;
		state_q == ST_RUN && stop_any && ce;
	endsequence

	sequence seq_brake_out;
		state_q == ST_BRAKE && dyn_brake && !ready;
	endsequence

	a_db_mode_direct: assert property (@(posedge core_clk) disable iff (reset)
		seq_run_stop and servo_servo_word_a_word_q[SERVO_WORD_A_DB_BIT] |=> seq_brake_out)
		else $error("dynamic brake mode did not brake at once"); // (R11)

	a_alarm_db_skip: assert property (@(posedge core_clk) disable iff (reset)
		seq_run_stop and alarm_db |=> seq_brake_out)
		else $error("brake-method alarm did not brake at once"); // (R9)

	a_decel_ready: assert property (@(posedge core_clk) disable iff (reset)
		state_q == ST_DECEL |-> ready && !dyn_brake)
		else $error("ready dropped during deceleration"); // (R2)

	a_power_abort: assert property (@(posedge core_clk) disable iff (reset)
		state_q == ST_DECEL && pwr_loss && ce |=> seq_brake_out)
		else $error("power loss did not abort the ramp"); // (R7)

	a_handover_60: assert property (@(posedge core_clk) disable iff (reset)
		state_q == ST_DECEL && motor_speed_fb <= DB_SPEED_RPM && ce
		|=> seq_brake_out)
		else $error("no brake handover at low speed"); // (R6)

	a_hold_sync: assert property (@(posedge core_clk) disable iff (reset)
		$rose(dyn_brake) |-> hold_brake == brake_ctl_q)
		else $error("hold brake not switched with dynamic brake"); // (R8)

	a_step_zero: assert property (@(posedge core_clk) disable iff (reset)
		seq_run_stop and !db_direct and decel_time_param_q == 16'h0000
		|=> step_stop && speed_cmd == 16'h0000 && ready)
		else $error("zero time constant did not step stop"); // (R5)

	a_ramp_fall: assert property (@(posedge core_clk) disable iff (reset)
		state_q == ST_DECEL && $past(state_q) == ST_DECEL
		|-> cmd_q <= $past(cmd_q))
		else $error("ramp command rose"); // (R13)

	a_decel_entry: assert property (@(posedge core_clk) disable iff (reset)
		seq_run_stop and !db_direct and decel_time_param_q != 16'h0000
		|=> state_q == ST_DECEL && ready)
		else $error("stop cause not taken"); // (R1)

	a_time_range: assert property (@(posedge core_clk) disable iff (reset)
		decel_time_param_q <= DECEL_MS_MAX)
		else $error("time constant out of range"); // (R3)

endmodule : ess_top

/* ess_pkg.sv */
// Constants and types shared by the emergency stop sequencer.
package ess_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned MS_PER_S    = 1000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
	localparam logic [15:0] DECEL_MS_MAX = 16'd5000;
	localparam logic [15:0] DB_SPEED_RPM = 16'd60;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SERVO_WORD_A   = 8'h00;
	localparam logic [7:0] OFS_DECEL  = 8'h04;
	localparam logic [7:0] OFS_RAPID  = 8'h08;
	localparam logic [7:0] OFS_CTRL   = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SERVO_WORD_A_DB_BIT     = 0;
	localparam int unsigned CTRL_BRK_BIT    = 0;
	localparam int unsigned CTRL_RESTART    = 1;
	localparam logic [15:0] SERVO_WORD_A_RST        = 16'h0000;
	localparam logic [15:0] DECEL_RST       = 16'h0000;
	localparam logic [15:0] RAPID_RST       = 16'h0000;
	localparam logic        CTRL_BRK_RST    = 1'b0;
	localparam int unsigned SYNC_W          = 4;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN,
		ST_DECEL,
		ST_STEP,
		ST_BRAKE
	} ess_state_t;
endpackage : ess_pkg

/* ess_motor_model.sv */
// Motor model that follows the speed command and coasts while braked.
`timescale 1ns/1ps
module ess_motor_model
	import ess_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Drive side
	input  wire logic [15:0] speed_cmd,
	input  wire logic        dyn_brake,
	input  wire logic        step_stop,
	// Feedback
	output logic [15:0]      motor_speed_fb
);
	// ----------------------------------------------------------------
	// Shaft speed
	// ----------------------------------------------------------------
	// A braked shaft sheds a fixed amount per cycle, far quicker than a
	// real one, so that a step stop reaches standstill in a short run.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			motor_speed_fb <= 16'h0000;
		end else if (dyn_brake || step_stop) begin
			motor_speed_fb <= (motor_speed_fb > 16'h0020) ?
				motor_speed_fb - 16'h0020 : 16'h0000;
		end else begin
			motor_speed_fb <= speed_cmd;
		end
	end
endmodule : ess_motor_model

/* tb_top.sv */
// Self-checking bench for the emergency stop sequencer.
`timescale 1ns/1ps
module tb_top
	import ess_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic        core_clk = 1'b0;
	logic        ce = 1'b1;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        ers;
	logic        ready;
	logic        dyn_brake;
	logic        hold_brake;
	logic        step_stop;
	logic [3:0]  cause = 4'h0;
	logic [15:0] speed_req = 16'h0;
	logic [15:0] motor_speed_fb;
	logic [15:0] speed_cmd;
	int          errors = 0;
	int          compares = 0;
	int          n;
	int          e;
	int          s;

	ess_top ess_top_inst (.core_clk, .reset, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_stop_in(cause[0]), .power_loss_in(cause[1]),
		.servo_alarm_in(cause[2]), .alarm_db_in(cause[3]), .speed_req,
		.motor_speed_fb, .speed_cmd, .ready, .dyn_brake, .hold_brake,
		.step_stop);
	ess_motor_model ess_motor_model_inst (.core_clk, .reset, .speed_cmd,
		.dyn_brake, .step_stop, .motor_speed_fb);

	always #25 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic int exp_cyc(int sp, int r, int t);
		return (sp - 60) * t * int'(CYC_PER_MS) / r;
	endfunction : exp_cyc

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: no pready", $time);
		end
		rd = prdata;
		ers = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic stop(input logic [3:0] c);
		@(posedge core_clk);
		cause <= c;
	endtask : stop

	// Ready must hold until the brake takes over, then all switch at once.
	task automatic brake_wait(output int c);
		c = 0;
		while (dyn_brake !== 1'b1 && c < 30000) begin
			if (ready !== 1'b1) chk(ready, 1'b1);
			@(negedge core_clk);
			c++;
		end
		chk({ready, dyn_brake, hold_brake, speed_cmd}, 19'h30000);
	endtask : brake_wait

	task automatic restart();
		@(posedge core_clk);
		cause <= 4'h0;
		repeat (8) @(posedge core_clk);
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (2) @(negedge core_clk);
		chk({ready, dyn_brake, step_stop}, 3'b100);
		@(posedge core_clk);
	endtask : restart

	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (90000) @(posedge core_clk);
		errors++;
		summarize();
	end

	initial begin
		void'($urandom(32'h9cd8));
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, OFS_SERVO_WORD_A, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({ers, rd}, 33'h100000000);
		apb(1'b1, OFS_DECEL, 32'd6000);
		apb(1'b0, OFS_DECEL, 32'h0);
		chk(rd, 32'd5000);
		apb(1'b1, OFS_RAPID, 32'd3000);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, OFS_SERVO_WORD_A, 32'h1);
		speed_req <= 16'd1500;
		for (int k = 0; k < 3; k++) begin
			stop(4'h1 << k);
			brake_wait(n);
			chk(n < 8, 1'b1);
			restart();
		end
		apb(1'b1, OFS_SERVO_WORD_A, 32'h0);
		// time constant set equal to the rapid acceleration constant.
		apb(1'b1, OFS_DECEL, 32'h1);
		for (int k = 0; k < 3; k++) begin
			s = (k == 0) ? 3000 : 200 + $urandom_range(2700);
			speed_req <= 16'(s);
			repeat (4) @(posedge core_clk);
			stop(k == 2 ? 4'h4 : 4'h1);
			brake_wait(n);
			e = exp_cyc(s, 3000, 1);
			chk(n >= e && n <= e + 10, 1'b1);
			restart();
		end
		stop(4'h1);
		repeat (100) @(posedge core_clk);
		cause <= 4'h3;
		brake_wait(n);
		chk(n < 8, 1'b1);
		restart();
		stop(4'hc);
		brake_wait(n);
		chk({n < 8, step_stop}, 2'b10);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({pready, rd}, 33'h1_0000_0c3c);
		@(posedge core_clk);
		cause <= 4'h0;
		repeat (8) @(posedge core_clk);
		ce <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		ce <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk({ready, dyn_brake}, 2'b01);
		restart();
		apb(1'b1, OFS_DECEL, 32'h0);
		speed_req <= 16'd3000;
		repeat (4) @(posedge core_clk);
		stop(4'h1);
		repeat (8) @(negedge core_clk);
		chk({step_stop, ready, speed_cmd}, 18'h30000);
		brake_wait(n);
		restart();
		summarize();
	end
endmodule : tb_top
